/* File: code_block_protection_checker.v */
// Operation
// - program memory splits into a boot block plus binary-bounded blocks
// - block address ranges depend on the memory size variant
// - each block has code-protect, write-protect and foreign-read controls
// - code-protect ignores core access, blocks external reads and writes
// - table writes into a write-protected block are refused
// - foreign-read protected block: reads from inside it return true data
// - foreign-read protected block: reads from outside return zeros
// - protection bits only change one to zero by writes
// - protection bits return to one only by chip or block erase
// - erases start only from the external programmer, never the core
// - eeprom code-protect blocks all external eeprom reads and writes
// - eeprom write-protect blocks core and external eeprom writes
// - core may always read the eeprom
// - table accesses reach any program address subject to block checks
// - device identification words are readable by table read
// - protection words are readable and writable by table access
// - config write-protect cannot be changed by core self-programming
// - six byte-wide protection words at consecutive addresses
// - block 2 and 3 controls exist only on 32K and 64K variants
// - foreign-read control one means unprotected
`timescale 1ns/1ns
`default_nettype none
`include "prot_consts.vh"
module code_block_protection_checker #(
    parameter [15:0] DEVICE_ID = 16'h1234  // arbitrary value
) (
    // clock and reset
    input  wire                i_clk_sys,
    input  wire                i_sys_rst,
    // variant
    input  wire [1:0]          i_mem_size,
    // core table access
    input  wire                i_core_req,
    input  wire                i_core_we,
    input  wire [21:0]         i_core_addr,
    input  wire [21:0]         i_core_pc,
    input  wire [7:0]          i_core_wdata,
    output reg                 o_core_ack,
    output reg  [7:0]          o_core_rdata,
    output reg                 o_core_refused,
    // core eeprom access
    input  wire                i_core_ee_req,
    input  wire                i_core_ee_we,
    output reg                 o_core_ee_ok,
    output reg                 o_core_ee_done,
    // external programmer
    input  wire                i_ext_req,
    input  wire                i_ext_we,
    input  wire                i_ext_ee,
    input  wire [21:0]         i_ext_addr,
    input  wire [7:0]          i_ext_wdata,
    input  wire                i_ext_chip_erase,
    input  wire                i_ext_blk_erase,
    input  wire [2:0]          i_ext_erase_blk,
    output reg                 o_ext_ack,
    output reg  [7:0]          o_ext_rdata,
    output reg                 o_ext_ok,
    // memory array side
    output reg                 o_mem_req,
    output reg                 o_mem_we,
    output reg  [21:0]         o_mem_addr,
    output reg  [7:0]          o_mem_wdata,
    input  wire [7:0]          i_mem_rdata,
    output reg                 o_ee_req,
    output reg                 o_ee_we,
    // current protection state
    output wire [3:0]          o_block_code_protect,
    output wire [3:0]          o_block_write_protect,
    output wire [3:0]          o_block_foreign_read_protect
);
    // ************************************************
    // protection words
    // ************************************************
    reg  [3:0] blk_cp_r;
    reg  [3:0] blk_wp_r;
    reg  [3:0] blk_rd_r;
    reg        boot_cp_r;
    reg        boot_wp_r;
    reg        boot_rd_r;
    reg        ee_cp_r;
    reg        ee_wp_r;
    reg        cfg_wp_r;
    wire [7:0] impl_wide;
    wire [3:0] impl_mask;
    assign impl_wide = (i_mem_size[1]) ? `MASK_LOW4 : `MASK_LOW2;
    assign impl_mask = impl_wide[3:0];
    // unimplemented block controls show as zero, as on readback
    assign o_block_code_protect         = blk_cp_r & impl_mask;
    assign o_block_write_protect        = blk_wp_r & impl_mask;
    assign o_block_foreign_read_protect = blk_rd_r & impl_mask;

    // readback of a protection or id word
    function [7:0] cfg_read;
        input [21:0] a;
        begin
            case (a)
                `CFG_CP_LOW:  cfg_read = {4'h0, blk_cp_r & impl_mask};
                `CFG_CP_HIGH: cfg_read = {ee_cp_r, boot_cp_r, 6'h00};
                `CFG_WP_LOW:  cfg_read = {4'h0, blk_wp_r & impl_mask};
                `CFG_WP_HIGH: cfg_read = {ee_wp_r, boot_wp_r, cfg_wp_r, 5'h00};
                `CFG_RD_LOW:  cfg_read = {4'h0, blk_rd_r & impl_mask};
                `CFG_RD_HIGH: cfg_read = {1'h0, boot_rd_r, 6'h00};
                `DEVID_LOW_ADDR:  cfg_read = DEVICE_ID[7:0];
                `DEVID_HIGH_ADDR: cfg_read = DEVICE_ID[15:8];
                default:      cfg_read = `ZERO_BYTE;
            endcase
        end
    endfunction

    function is_cfg;
        input [21:0] a;
        begin
            is_cfg = (a >= `CFG_CP_LOW) && (a <= `CFG_RD_HIGH);
        end
    endfunction

    function is_id;
        input [21:0] a;
        begin
            is_id = (a == `DEVID_LOW_ADDR) || (a == `DEVID_HIGH_ADDR);
        end
    endfunction

    // select one control of a block, boot block included
    function pick;
        input [3:0] blk_bits;
        input       boot_bit;
        input [2:0] blk;
        begin
            if (blk == `BLK_BOOT) pick = boot_bit;
            else if (blk[2]) pick = 1'b1;
            else pick = blk_bits[blk[1:0]];
        end
    endfunction

    // ************************************************
    // address decode
    // ************************************************
    wire [2:0] core_blk;
    wire [2:0] pc_blk;
    wire [2:0] ext_blk;
    block_decode u_dec_core (
        .i_size (i_mem_size),
        .i_addr (i_core_addr),
        .o_blk  (core_blk)
    );
    block_decode u_dec_pc (
        .i_size (i_mem_size),
        .i_addr (i_core_pc),
        .o_blk  (pc_blk)
    );
    block_decode u_dec_ext (
        .i_size (i_mem_size),
        .i_addr (i_ext_addr),
        .o_blk  (ext_blk)
    );

    // ************************************************
    // permission checks
    // ************************************************
    reg core_wr_ok;
    reg core_rd_true;
    reg core_mem;
    reg ext_mem_ok;
    always @* begin
        core_mem     = (core_blk != `BLK_NONE);
        // code-protect deliberately not consulted for the core
        core_wr_ok   = core_mem && pick(blk_wp_r, boot_wp_r, core_blk);
        core_rd_true = core_mem && ((core_blk == pc_blk) ||
                       pick(blk_rd_r, boot_rd_r, core_blk));
        ext_mem_ok   = (ext_blk != `BLK_NONE) &&
                       pick(blk_cp_r, boot_cp_r, ext_blk);
    end

    // ************************************************
    // clear-only write of a protection word
    // ************************************************
    wire       core_cfg_wr;
    wire       ext_cfg_wr;
    wire [21:0] cfg_addr;
    wire [7:0]  cfg_data;
    assign core_cfg_wr = i_core_req && i_core_we && is_cfg(i_core_addr) && cfg_wp_r;
    assign ext_cfg_wr  = i_ext_req && i_ext_we && !i_ext_ee && is_cfg(i_ext_addr);
    // programmer has priority over the core
    assign cfg_addr = ext_cfg_wr ? i_ext_addr : i_core_addr;
    assign cfg_data = ext_cfg_wr ? i_ext_wdata : i_core_wdata;

    always @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            // unprogrammed state; bits live in nonvolatile cells in silicon
            blk_cp_r  <= 4'hF;
            blk_wp_r  <= 4'hF;
            blk_rd_r  <= 4'hF;
            boot_cp_r <= 1'b1;
            boot_wp_r <= 1'b1;
            boot_rd_r <= 1'b1;
            ee_cp_r   <= 1'b1;
            ee_wp_r   <= 1'b1;
            cfg_wp_r  <= 1'b1;
        end else if (i_ext_chip_erase) begin
            blk_cp_r  <= 4'hF;
            blk_wp_r  <= 4'hF;
            blk_rd_r  <= 4'hF;
            boot_cp_r <= 1'b1;
            boot_wp_r <= 1'b1;
            boot_rd_r <= 1'b1;
            ee_cp_r   <= 1'b1;
            ee_wp_r   <= 1'b1;
            cfg_wp_r  <= 1'b1;
        end else if (i_ext_blk_erase) begin
            if (i_ext_erase_blk == `BLK_BOOT) begin
                boot_cp_r <= 1'b1;
                boot_wp_r <= 1'b1;
                boot_rd_r <= 1'b1;
            end else if (!i_ext_erase_blk[2]) begin
                blk_cp_r[i_ext_erase_blk[1:0]] <= 1'b1;
                blk_wp_r[i_ext_erase_blk[1:0]] <= 1'b1;
                blk_rd_r[i_ext_erase_blk[1:0]] <= 1'b1;
            end
        end else if (ext_cfg_wr || core_cfg_wr) begin
            case (cfg_addr)
                `CFG_CP_LOW:  blk_cp_r <= blk_cp_r & (cfg_data[3:0] | ~impl_mask);
                `CFG_CP_HIGH: begin
                    ee_cp_r   <= ee_cp_r & cfg_data[`BIT_EE];
                    boot_cp_r <= boot_cp_r & cfg_data[`BIT_BOOT];
                end
                `CFG_WP_LOW:  blk_wp_r <= blk_wp_r & (cfg_data[3:0] | ~impl_mask);
                `CFG_WP_HIGH: begin
                    ee_wp_r   <= ee_wp_r & cfg_data[`BIT_EE];
                    boot_wp_r <= boot_wp_r & cfg_data[`BIT_BOOT];
                    if (ext_cfg_wr)
                        cfg_wp_r <= cfg_wp_r & cfg_data[`BIT_CFGWP];
                end
                `CFG_RD_LOW:  blk_rd_r <= blk_rd_r & (cfg_data[3:0] | ~impl_mask);
                `CFG_RD_HIGH: boot_rd_r <= boot_rd_r & cfg_data[`BIT_BOOT];
                default: ;
            endcase
        end
    end

    // ************************************************
    // access routing, one registered answer per request
    // ************************************************
    always @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_core_ack     <= 1'b0;
            o_core_rdata   <= `ZERO_BYTE;
            o_core_refused <= 1'b0;
            o_core_ee_ok   <= 1'b0;
            o_core_ee_done <= 1'b0;
            o_ext_ack      <= 1'b0;
            o_ext_rdata    <= `ZERO_BYTE;
            o_ext_ok       <= 1'b0;
            o_mem_req      <= 1'b0;
            o_mem_we       <= 1'b0;
            o_mem_addr     <= 22'h000000;
            o_mem_wdata    <= `ZERO_BYTE;
            o_ee_req       <= 1'b0;
            o_ee_we        <= 1'b0;
        end else begin
            o_core_ack     <= i_core_req;
            o_core_ee_done <= i_core_ee_req;
            o_ext_ack      <= i_ext_req;
            o_mem_req      <= 1'b0;
            o_mem_we       <= 1'b0;
            o_ee_req       <= 1'b0;
            o_ee_we        <= 1'b0;
            o_core_refused <= 1'b0;
            o_ext_ok       <= 1'b0;
            o_core_ee_ok   <= 1'b0;
            // eeprom: core reads always pass, writes need write-protect bit still one
            if (i_core_ee_req) begin
                o_core_ee_ok <= !i_core_ee_we || ee_wp_r;
                o_ee_req     <= !i_core_ee_we || ee_wp_r;
                o_ee_we      <= i_core_ee_we && ee_wp_r;
            end else if (i_ext_req && i_ext_ee) begin
                o_ext_ok <= ee_cp_r && (!i_ext_we || ee_wp_r);
                o_ee_req <= ee_cp_r && (!i_ext_we || ee_wp_r);
                o_ee_we  <= ee_cp_r && i_ext_we && ee_wp_r;
            end
            if (i_ext_req && !i_ext_ee) begin
                o_ext_rdata <= `ZERO_BYTE;
                if (is_cfg(i_ext_addr) || is_id(i_ext_addr)) begin
                    o_ext_ok    <= 1'b1;
                    o_ext_rdata <= cfg_read(i_ext_addr);
                end else if (ext_mem_ok) begin
                    o_ext_ok    <= 1'b1;
                    o_mem_req   <= 1'b1;
                    o_mem_we    <= i_ext_we;
                    o_mem_addr  <= i_ext_addr;
                    o_mem_wdata <= i_ext_wdata;
                    o_ext_rdata <= i_mem_rdata;
                end
            end else if (i_core_req) begin
                o_core_rdata <= `ZERO_BYTE;
                if (is_cfg(i_core_addr) || is_id(i_core_addr)) begin
                    o_core_rdata   <= cfg_read(i_core_addr);
                    o_core_refused <= i_core_we && !cfg_wp_r;
                end else if (i_core_we) begin
                    if (core_wr_ok) begin
                        o_mem_req   <= 1'b1;
                        o_mem_we    <= 1'b1;
                        o_mem_addr  <= i_core_addr;
                        o_mem_wdata <= i_core_wdata;
                    end else begin
                        o_core_refused <= 1'b1;
                    end
                end else if (core_rd_true) begin
                    o_mem_req    <= 1'b1;
                    o_mem_addr   <= i_core_addr;
                    o_core_rdata <= i_mem_rdata;
                end
            end
        end
    end
endmodule
`default_nettype wire

/* File: prot_consts.vh */
`ifndef PROT_CONSTS_VH
`define PROT_CONSTS_VH
// configuration word addresses (22-bit table address space)
`define ADDR_W            22
`define CFG_CP_LOW        22'h300008
`define CFG_CP_HIGH       22'h300009
`define CFG_WP_LOW        22'h30000A
`define CFG_WP_HIGH       22'h30000B
`define CFG_RD_LOW        22'h30000C
`define CFG_RD_HIGH       22'h30000D
`define DEVID_LOW_ADDR    22'h3FFFFE
`define DEVID_HIGH_ADDR   22'h3FFFFF
// field positions
`define BIT_EE            7
`define BIT_BOOT          6
`define BIT_CFGWP         5
// implemented-bit masks
`define MASK_LOW4         8'h0F
`define MASK_LOW2         8'h03
`define MASK_HIGH_CP      8'hC0
`define MASK_HIGH_WP      8'hE0
`define MASK_HIGH_RD      8'h40
`define ERASED_BYTE       8'hFF
`define ZERO_BYTE         8'h00
// memory size codes
`define SIZE_8K           2'h0
`define SIZE_16K          2'h1
`define SIZE_32K          2'h2
`define SIZE_64K          2'h3
// block indices
`define BLK_BOOT          3'h4
`define BLK_NONE          3'h7
`endif

/* File: block_decode.v */
`timescale 1ns/1ns
`default_nettype none
// maps a program address to its protection block for the given size
module block_decode (
    // size and address
    input  wire [1:0]          i_size,
    input  wire [21:0]         i_addr,
    // block: 0..3 numbered, 4 boot, 7 unimplemented
    output reg  [2:0]          o_blk
);
    always @* begin
        o_blk = `BLK_NONE;
        case (i_size)
            `SIZE_8K: begin
                if (i_addr < 22'h000200) o_blk = `BLK_BOOT;
                else if (i_addr < 22'h001000) o_blk = 3'h0;
                else if (i_addr < 22'h002000) o_blk = 3'h1;
            end
            `SIZE_16K: begin
                if (i_addr < 22'h000800) o_blk = `BLK_BOOT;
                else if (i_addr < 22'h002000) o_blk = 3'h0;
                else if (i_addr < 22'h004000) o_blk = 3'h1;
            end
            `SIZE_32K: begin
                if (i_addr < 22'h000800) o_blk = `BLK_BOOT;
                else if (i_addr < 22'h002000) o_blk = 3'h0;
                else if (i_addr < 22'h004000) o_blk = 3'h1;
                else if (i_addr < 22'h006000) o_blk = 3'h2;
                else if (i_addr < 22'h008000) o_blk = 3'h3;
            end
            default: begin
                if (i_addr < 22'h000800) o_blk = `BLK_BOOT;
                else if (i_addr < 22'h004000) o_blk = 3'h0;
                else if (i_addr < 22'h008000) o_blk = 3'h1;
                else if (i_addr < 22'h00C000) o_blk = 3'h2;
                else if (i_addr < 22'h010000) o_blk = 3'h3;
            end
        endcase
    end
endmodule
`default_nettype wire

/* File: cbp_chk_chk.sv */
`timescale 1ns/1ns
`default_nettype none
module cbp_chk (
    // clock and reset
    input  wire logic        i_clk_sys,
    input  wire logic        i_sys_rst,
    // core, programmer and array inputs
    input  wire logic [1:0]  i_mem_size,
    input  wire logic        i_core_req,
    input  wire logic        i_core_we,
    input  wire logic [21:0] i_core_addr,
    input  wire logic [21:0] i_core_pc,
    input  wire logic        i_core_ee_req,
    input  wire logic        i_core_ee_we,
    input  wire logic        i_ext_req,
    input  wire logic        i_ext_chip_erase,
    input  wire logic        i_ext_blk_erase,
    input  wire logic [7:0]  i_mem_rdata,
    // answers
    input  wire logic        o_core_ack,
    input  wire logic [7:0]  o_core_rdata,
    input  wire logic        o_core_refused,
    input  wire logic        o_core_ee_ok,
    input  wire logic        o_core_ee_done,
    input  wire logic        o_mem_we,
    input  wire logic [3:0]  o_block_code_protect,
    input  wire logic [3:0]  o_block_write_protect,
    input  wire logic [3:0]  o_block_foreign_read_protect
);
    // ********
    // block decode, 64K variant only to keep it small
    // ********
    function automatic logic [2:0] blk64(input logic [21:0] a);
        if (a < 22'h000800) return 3'h4;
        if (a < 22'h004000) return 3'h0;
        if (a < 22'h010000) return {1'b0, a[15:14]};
        return 3'h7;
    endfunction
    logic [2:0]  ba;
    logic [2:0]  bp;
    logic        sel;
    logic [11:0] bits;
    assign ba = blk64(i_core_addr);
    assign bp = blk64(i_core_pc);
    assign sel = i_core_req && !i_ext_req && i_mem_size == 2'h3 && ba < 3'h4;
    assign bits = {o_block_code_protect, o_block_write_protect, o_block_foreign_read_protect};
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_sys_rst);
    ack_after_req_a: assert property (i_core_req |=> o_core_ack) else $error("core ack missing");
    ack_needs_req_a: assert property (o_core_ack |-> $past(i_core_req)) else $error("stray ack");
    write_refused_a: assert property (sel && i_core_we && !o_block_write_protect[ba[1:0]]
        |=> o_core_refused && !o_mem_we) else $error("protected write passed");
    refused_quiet_a: assert property (o_core_refused |-> o_core_ack && !o_mem_we)
        else $error("refused write reached array");
    foreign_zero_a: assert property (sel && !i_core_we && bp != ba
        && !o_block_foreign_read_protect[ba[1:0]] |=> o_core_rdata == 8'h00)
        else $error("foreign read not zeroed");
    own_read_a: assert property (sel && !i_core_we && bp == ba
        |=> o_core_rdata == $past(i_mem_rdata)) else $error("own block read wrong");
    bits_rise_erase_a: assert property (|(bits & ~$past(bits))
        |-> $past(i_ext_chip_erase || i_ext_blk_erase)) else $error("bit rose without erase");
    ee_read_ok_a: assert property (i_core_ee_req && !i_core_ee_we
        |=> o_core_ee_ok && o_core_ee_done) else $error("core eeprom read denied");
    cover property (sel && !i_core_we && bp != ba ##1 o_core_rdata == 8'h00);
    cover property (o_core_refused);
    cover property (i_ext_chip_erase ##1 &o_block_write_protect);
endmodule
`default_nettype wire

/* File: mem_array_model.sv */
`timescale 1ns/1ns
`default_nettype none
module mem_array_model (
    // address presented
    input  wire logic [21:0] i_addr,
    // array data
    output logic      [7:0]  o_rdata
);
    // pattern differs per byte so a wrong address shows up
    assign o_rdata = i_addr[7:0] ^ i_addr[15:8] ^ 8'hA5;
endmodule
`default_nettype wire

/* File: tb_code_block_protection_checker.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_code_block_protection_checker;
    // ********
    // stimulus and model state
    // ********
    localparam logic [15:0] DEV_ID = 16'h1234; // arbitrary value
    logic i_clk_sys = 1'b0, i_sys_rst = 1'b1, i_core_req = '0, i_core_we = '0;
    logic i_core_ee_req = '0, i_core_ee_we = '0, i_ext_req = '0, i_ext_we = '0, i_ext_ee = '0;
    logic i_ext_chip_erase = '0, i_ext_blk_erase = '0;
    logic [1:0] i_mem_size = 2'h3;
    logic [2:0] i_ext_erase_blk = '0;
    logic [21:0] i_core_addr = '0, i_core_pc = '0, i_ext_addr = '0, ra, rp;
    logic [7:0] i_core_wdata = '0, i_ext_wdata = '0, cfg [6];
    wire [7:0] i_mem_rdata, o_core_rdata, o_ext_rdata, o_mem_wdata;
    wire o_core_ack, o_core_refused, o_core_ee_ok, o_core_ee_done, o_ext_ack, o_ext_ok;
    wire o_mem_req, o_mem_we, o_ee_req, o_ee_we;
    wire [21:0] o_mem_addr;
    wire [3:0] o_block_code_protect, o_block_write_protect, o_block_foreign_read_protect;
    int failures = 0, checked = 0, seed = 27, cyc = 0;
    int bnd [4][5] = '{'{'h200, 'h1000, 'h2000, 'h2000, 'h2000},
        '{'h800, 'h2000, 'h4000, 'h4000, 'h4000}, '{'h800, 'h2000, 'h4000, 'h6000, 'h8000},
        '{'h800, 'h4000, 'h8000, 'hC000, 'h10000}};
    code_block_protection_checker #(.DEVICE_ID(DEV_ID)) dut (.*);
    mem_array_model mem (.i_addr(i_ext_req ? i_ext_addr : i_core_addr), .o_rdata(i_mem_rdata));
    always #20 i_clk_sys = ~i_clk_sys;
    // long enough for every test with wide margin
    always @(posedge i_clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            failures++;
            stop_test;
        end
    end
    function automatic int blk(int a);
        if (a < bnd[i_mem_size][0]) return 4;
        for (int i = 0; i < 4; i++) if (a < bnd[i_mem_size][i + 1]) return i;
        return 7;
    endfunction
    function automatic logic [7:0] memv(logic [21:0] a);
        return a[7:0] ^ a[15:8] ^ 8'hA5;
    endfunction
    // w selects the word pair: 0 code, 2 write, 4 foreign read
    function automatic logic pbit(int w, int b);
        return b == 4 ? cfg[w + 1][6] : cfg[w][b];
    endfunction
    function automatic logic [7:0] msk(int i);
        if (i[0]) return i == 1 ? 8'hC0 : (i == 3 ? 8'hE0 : 8'h40);
        return i_mem_size[1] ? 8'h0F : 8'h03;
    endfunction
    // ********
    // checks and bus cycles
    // ********
    task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic chk_bits;
        chk("code bits", o_block_code_protect, cfg[0] & msk(0));
        chk("write bits", o_block_write_protect, cfg[2] & msk(2));
        chk("read bits", o_block_foreign_read_protect, cfg[4] & msk(4));
    endtask
    task automatic rst(logic [1:0] s);
        @(negedge i_clk_sys);
        i_sys_rst = 1'b1;
        i_mem_size = s;
        repeat (5) @(negedge i_clk_sys);
        i_sys_rst = 1'b0;
        cfg = '{default: 8'hFF};
        chk_bits;
    endtask
    task automatic core(logic we, logic [21:0] a, logic [21:0] pc, logic [7:0] wd);
        int b, ix;
        logic rf;
        logic mr;
        logic [7:0] rd;
        b = blk(a);
        ix = a - 'h300008;
        rf = 1'b0;
        mr = 1'b0;
        rd = 8'h00;
        if (ix >= 0 && ix < 6) begin
            rf = we && !cfg[3][5];
            if (we && !rf) cfg[ix] &= wd | (ix == 3 ? 8'h20 : 8'h00);
            rd = cfg[ix] & msk(ix);
        end else if (a >= 'h3FFFFE) rd = a[0] ? DEV_ID[15:8] : DEV_ID[7:0];
        else if (b != 7) begin
            rf = we && !pbit(2, b);
            mr = we ? !rf : (blk(pc) == b || pbit(4, b));
            if (blk(pc) == b || pbit(4, b)) rd = memv(a);
        end
        @(negedge i_clk_sys);
        {i_core_req, i_core_we, i_core_addr, i_core_pc, i_core_wdata} = {1'b1, we, a, pc, wd};
        @(negedge i_clk_sys);
        i_core_req = 1'b0;
        chk("core ack", o_core_ack, 8'h01);
        chk("core refused", o_core_refused, rf);
        if (!we) chk("core rdata", o_core_rdata, rd);
        chk("mem strobe", o_mem_req, mr);
        chk("mem write", o_mem_we, we && mr);
        chk_bits;
    endtask
    task automatic ext(logic we, logic ee, logic [21:0] a, logic [7:0] wd);
        logic ok;
        ok = ee ? cfg[1][7] : blk(a) != 7 && pbit(0, blk(a));
        if (we) cfg[a - 'h300008] &= wd;
        @(negedge i_clk_sys);
        {i_ext_req, i_ext_we, i_ext_ee, i_ext_addr, i_ext_wdata} = {1'b1, we, ee, a, wd};
        @(negedge i_clk_sys);
        i_ext_req = 1'b0;
        chk("ext ack", o_ext_ack, 8'h01);
        if (!we) chk("ext ok", o_ext_ok, ok);
        if (!we && !ee) chk("ext rdata", o_ext_rdata, ok ? memv(a) : 8'h00);
        chk_bits;
    endtask
    task automatic cee(logic we);
        @(negedge i_clk_sys);
        {i_core_ee_req, i_core_ee_we} = {1'b1, we};
        @(negedge i_clk_sys);
        i_core_ee_req = 1'b0;
        chk("ee done", o_core_ee_done, 8'h01);
        chk("ee ok", o_core_ee_ok, !we || cfg[3][7]);
        chk("ee write", o_ee_we, we && cfg[3][7]);
    endtask
    task automatic erase(logic chip, int b);
        @(negedge i_clk_sys);
        {i_ext_chip_erase, i_ext_blk_erase, i_ext_erase_blk} = {chip, !chip, 3'(b)};
        @(negedge i_clk_sys);
        {i_ext_chip_erase, i_ext_blk_erase} = 2'h0;
        if (chip) cfg = '{default: 8'hFF};
        else for (int w = 0; w < 6; w += 2) if (b == 4) cfg[w + 1][6] = 1'b1; else cfg[w][b] = 1'b1;
        chk_bits;
    endtask
    task automatic stop_test;
        $display("checks %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        for (int s = 0; s < 4; s++) begin
            rst(2'(s));
            core(1'b1, 'h30000C, '0, 8'h00);
            core(1'b1, 'h30000D, '0, 8'h00);
            core(1'b0, 'h30000C, '0, 8'h00);
            core(1'b0, 'h3FFFFE, '0, 8'h00);
            core(1'b0, 'h3FFFFF, '0, 8'h00);
            for (int i = 0; i < 5; i++) begin
                core(1'b0, 22'(bnd[s][i]), 22'(bnd[s][i] - 1), 8'h00);
                core(1'b0, 22'(bnd[s][i]), 22'(bnd[s][i]), 8'h00);
            end
            repeat (60) begin
                ra = 22'($unsigned($random(seed)) % (bnd[s][4] + 'h100));
                rp = 22'($unsigned($random(seed)) % (bnd[s][4] + 'h100));
                core(1'b0, ra, rp, 8'h00);
            end
            $display("size %0d map test done", s);
        end
        rst(2'h3);
        core(1'b1, 'h30000A, '0, 8'hFE);
        core(1'b1, 'h30000A, '0, 8'hFF);
        core(1'b1, 'h000900, 'h000900, 8'h11);
        core(1'b1, 'h004000, 'h000900, 8'h22);
        erase(1'b0, 0);
        core(1'b1, 'h000900, 'h000900, 8'h11);
        core(1'b1, 'h300008, '0, 8'hFD);
        ext(1'b0, 1'b0, 'h004000, 8'h00);
        ext(1'b0, 1'b0, 'h000900, 8'h00);
        core(1'b0, 'h004000, 'h004000, 8'h00);
        $display("write and code protect test done");
        core(1'b1, 'h30000B, '0, 8'h1F);
        core(1'b0, 'h30000B, '0, 8'h00);
        cee(1'b1);
        cee(1'b0);
        ext(1'b0, 1'b1, '0, 8'h00);
        core(1'b1, 'h300009, '0, 8'h7F);
        ext(1'b0, 1'b1, '0, 8'h00);
        cee(1'b0);
        core(1'b1, 'h000100, 'h000900, 8'h33);
        ext(1'b1, 1'b0, 'h30000B, 8'hDF);
        core(1'b1, 'h300008, '0, 8'h00);
        erase(1'b1, 0);
        for (int i = 0; i < 6; i++) core(1'b1, 22'('h300008 + i), '0, 8'h00);
        for (int b = 0; b < 5; b++) erase(1'b0, b);
        erase(1'b1, 0);
        $display("eeprom and erase test done");
        stop_test;
    end
endmodule
bind code_block_protection_checker cbp_chk u_chk (.*);
`default_nettype wire
